//--- rtl/stat_counters.sv
// bank of five mac statistic counters with a near-full event output
// assumes event inputs are one-cycle pulses on clk_in; the enable and
// mask bits come from control registers held elsewhere
`timescale 1ns/1ps
module stat_counters
  import stat_counters_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // register access
  input wire reg_req_type reg_req_in,
  output logic [31:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // counting control
  input wire logic counters_global_on_in,
  input wire logic [NUM_COUNTERS-1:0] per_counter_mask_in,
  // frame events
  input wire rx_frame_info_type rx_info_in,
  input wire tx_event_type tx_event_in,
  // near-full pulse toward the interrupt status register
  output logic counter_near_full_event_out
);

  logic [NUM_COUNTERS-1:0][31:0] count_reg;
  logic [NUM_COUNTERS-1:0] write_hit;
  logic [NUM_COUNTERS-1:0] read_hit;
  logic [NUM_COUNTERS-1:0] event_vec;
  logic [NUM_COUNTERS-1:0] count_en;
  logic [NUM_COUNTERS-1:0] near_hit;
  logic [31:0] rdata_next;
  logic [31:0] rdata_reg;
  logic rvalid_reg;
  logic near_full_reg;
  logic in_range_err;
  logic rx_clean;

  function automatic logic [7:0] slot_addr(input int idx);
    case (idx)
      IDX_IN_RANGE: slot_addr = ADDR_IN_RANGE;
      IDX_LATE: slot_addr = ADDR_LATE;
      IDX_PAUSE: slot_addr = ADDR_PAUSE;
      IDX_CTRL_TX: slot_addr = ADDR_CTRL_TX;
      default: slot_addr = ADDR_MCST;
    endcase
  endfunction : slot_addr

  // 16-bit slots keep their upper half at zero so reads show zeros
  function automatic logic [31:0] slot_mask(input int idx);
    if (idx == IDX_LATE || idx == IDX_MCST) begin
      slot_mask = MASK_32;
    end else begin
      slot_mask = MASK_16;
    end
  endfunction : slot_mask

  function automatic logic [31:0] slot_near(input int idx);
    if (idx == IDX_LATE || idx == IDX_MCST) begin
      slot_near = NEAR_32;
    end else begin
      slot_near = NEAR_16;
    end
  endfunction : slot_near

  function automatic logic [31:0] bump(input logic [31:0] cur,
                                       input logic [31:0] mask);
    bump = (cur + 32'h00000001) & mask;
  endfunction : bump

  function automatic logic [NUM_COUNTERS-1:0] decode(input logic [7:0] a);
    decode = '0;
    for (int i = 0; i < NUM_COUNTERS; i++) begin
      decode[i] = (a == slot_addr(i));
    end
  endfunction : decode

  // length/type values above the client maximum are ether types, not errors
  always_comb begin
    in_range_err = 1'b0;
    if (rx_info_in.length_type >= MIN_UNPADDED &&
        rx_info_in.length_type <= MAX_CLIENT &&
        rx_info_in.length_type != rx_info_in.data_octets) begin
      in_range_err = 1'b1;
    end
    if (rx_info_in.length_type < MIN_UNPADDED &&
        rx_info_in.data_octets > MIN_UNPADDED) begin
      in_range_err = 1'b1;
    end
  end

  assign rx_clean = !rx_info_in.too_long && !rx_info_in.fcs_error &&
                    !rx_info_in.align_error && !rx_info_in.overrun;

  always_comb begin
    event_vec = '0;
    event_vec[IDX_IN_RANGE] = rx_info_in.done && in_range_err;
    event_vec[IDX_LATE] = tx_event_in.collision &&
                          tx_event_in.past_one_slot;
    event_vec[IDX_PAUSE] = rx_info_in.done && rx_clean &&
                           rx_info_in.is_control &&
                           rx_info_in.control_opcode == PAUSE_OPCODE;
    event_vec[IDX_CTRL_TX] = tx_event_in.ctrl_frame_sent &&
                             !tx_event_in.ctrl_from_host;
    event_vec[IDX_MCST] = rx_info_in.done && rx_clean && !in_range_err &&
                          rx_info_in.dest_addr[GROUP_BIT] &&
                          rx_info_in.dest_addr != BROADCAST;
  end

  assign count_en = event_vec & {NUM_COUNTERS{counters_global_on_in}} &
                    ~per_counter_mask_in;
  assign write_hit = reg_req_in.wr ? decode(reg_req_in.addr) : '0;
  assign read_hit = decode(reg_req_in.addr);

  // a write in the same cycle as an event wins; the event is not counted
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_reg <= {NUM_COUNTERS{COUNT_RESET}};
    end else begin
      for (int i = 0; i < NUM_COUNTERS; i++) begin
        if (write_hit[i]) begin
          count_reg[i] <= reg_req_in.wdata & slot_mask(i);
        end else if (count_en[i]) begin
          count_reg[i] <= bump(count_reg[i], slot_mask(i));
        end
      end
    end
  end

  // only a counted step onto the threshold fires, not a software load
  always_comb begin
    near_hit = '0;
    for (int i = 0; i < NUM_COUNTERS; i++) begin
      near_hit[i] = count_en[i] && !write_hit[i] &&
                    bump(count_reg[i], slot_mask(i)) == slot_near(i);
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      near_full_reg <= 1'b0;
    end else begin
      near_full_reg <= |near_hit;
    end
  end

  always_comb begin
    rdata_next = READ_UNMAPPED;
    for (int i = 0; i < NUM_COUNTERS; i++) begin
      if (read_hit[i]) begin
        rdata_next = count_reg[i];
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_reg <= 32'h00000000;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= reg_req_in.rd;
      if (reg_req_in.rd) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign reg_rvalid_out = rvalid_reg;
  assign counter_near_full_event_out = near_full_reg;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  a_length_wrap: assert property (
    count_en[IDX_IN_RANGE] && !write_hit[IDX_IN_RANGE] &&
    count_reg[IDX_IN_RANGE] == 32'h0000FFFF
    |=> count_reg[IDX_IN_RANGE] == 32'h00000000)
    else $error("length error counter did not wrap");

  a_length_step: assert property (
    rx_info_in.done && counters_global_on_in &&
    !per_counter_mask_in[IDX_IN_RANGE] && !write_hit[IDX_IN_RANGE] &&
    rx_info_in.length_type >= MIN_UNPADDED &&
    rx_info_in.length_type <= MAX_CLIENT &&
    rx_info_in.length_type != rx_info_in.data_octets
    |=> count_reg[IDX_IN_RANGE] ==
        ((($past(count_reg[IDX_IN_RANGE])) + 32'h00000001) & MASK_16))
    else $error("in-range length mismatch not counted");

  a_short_len: assert property (
    rx_info_in.done && counters_global_on_in &&
    !per_counter_mask_in[IDX_IN_RANGE] && !write_hit[IDX_IN_RANGE] &&
    rx_info_in.length_type < MIN_UNPADDED &&
    rx_info_in.data_octets > MIN_UNPADDED
    |=> count_reg[IDX_IN_RANGE] != $past(count_reg[IDX_IN_RANGE]))
    else $error("short length field not counted");

  a_length_near: assert property (
    count_en[IDX_IN_RANGE] && !write_hit[IDX_IN_RANGE] &&
    count_reg[IDX_IN_RANGE] == 32'h0000BFFF
    |=> counter_near_full_event_out)
    else $error("no near-full at length threshold");

  a_gate_off: assert property (
    !counters_global_on_in && !reg_req_in.wr |=> $stable(count_reg))
    else $error("counter moved while globally off");

  a_gate_mask: assert property (
    per_counter_mask_in[IDX_LATE] && !write_hit[IDX_LATE]
    |=> $stable(count_reg[IDX_LATE]))
    else $error("masked late collision counter moved");

  a_late_early: assert property (
    !tx_event_in.past_one_slot && !write_hit[IDX_LATE]
    |=> $stable(count_reg[IDX_LATE]))
    else $error("early collision counted as late");

  a_late_wrap: assert property (
    count_en[IDX_LATE] && !write_hit[IDX_LATE] &&
    count_reg[IDX_LATE] == 32'hFFFFFFFF
    |=> count_reg[IDX_LATE] == 32'h00000000)
    else $error("late collision counter did not wrap");

  a_late_near: assert property (
    count_en[IDX_LATE] && !write_hit[IDX_LATE] &&
    count_reg[IDX_LATE] == 32'hBFFFFFFF
    |=> counter_near_full_event_out ##1 !counter_near_full_event_out)
    else $error("late collision near-full pulse wrong");

  a_pause_only: assert property (
    rx_info_in.is_control && rx_info_in.control_opcode != PAUSE_OPCODE &&
    !write_hit[IDX_PAUSE]
    |=> $stable(count_reg[IDX_PAUSE]))
    else $error("non-pause control frame counted");

  a_pause_wrap: assert property (
    count_en[IDX_PAUSE] && !write_hit[IDX_PAUSE] &&
    count_reg[IDX_PAUSE] == 32'h0000FFFF
    |=> count_reg[IDX_PAUSE] == 32'h00000000)
    else $error("pause counter did not wrap");

  a_pause_near: assert property (
    count_en[IDX_PAUSE] && !write_hit[IDX_PAUSE] &&
    count_reg[IDX_PAUSE] == 32'h0000BFFF
    |=> counter_near_full_event_out)
    else $error("no near-full at pause threshold");

  a_host_ctrl: assert property (
    tx_event_in.ctrl_from_host && !write_hit[IDX_CTRL_TX]
    |=> $stable(count_reg[IDX_CTRL_TX]))
    else $error("host control frame counted");

  a_ctrl_near: assert property (
    count_en[IDX_CTRL_TX] && !write_hit[IDX_CTRL_TX] &&
    count_reg[IDX_CTRL_TX] == 32'h0000BFFF
    |=> counter_near_full_event_out)
    else $error("no near-full at sent control threshold");

  a_ctrl_wrap: assert property (
    count_en[IDX_CTRL_TX] && !write_hit[IDX_CTRL_TX] &&
    count_reg[IDX_CTRL_TX] == 32'h0000FFFF
    |=> count_reg[IDX_CTRL_TX] == 32'h00000000)
    else $error("sent control counter did not wrap");

  a_mcst_bcast: assert property (
    rx_info_in.dest_addr == BROADCAST && !write_hit[IDX_MCST]
    |=> $stable(count_reg[IDX_MCST]))
    else $error("broadcast counted as multicast");

  a_mcst_error: assert property (
    (rx_info_in.fcs_error || rx_info_in.overrun) && !write_hit[IDX_MCST]
    |=> $stable(count_reg[IDX_MCST]))
    else $error("bad frame counted as multicast");

  a_mcst_wrap: assert property (
    count_en[IDX_MCST] && !write_hit[IDX_MCST] &&
    count_reg[IDX_MCST] == 32'hFFFFFFFF
    |=> count_reg[IDX_MCST] == 32'h00000000)
    else $error("multicast counter did not wrap");

  a_mcst_near: assert property (
    count_en[IDX_MCST] && !write_hit[IDX_MCST] &&
    count_reg[IDX_MCST] == 32'hBFFFFFFF
    |=> counter_near_full_event_out)
    else $error("no near-full at multicast threshold");

  a_write_load: assert property (
    write_hit[IDX_MCST]
    |=> count_reg[IDX_MCST] == $past(reg_req_in.wdata))
    else $error("write did not load multicast counter");

  a_read_data: assert property (
    reg_req_in.rd && reg_req_in.addr == ADDR_CTRL_TX
    |=> reg_rvalid_out && reg_rdata_out == $past(count_reg[IDX_CTRL_TX]))
    else $error("read returned wrong sent control count");

  a_near_cause: assert property (
    counter_near_full_event_out |-> $past(|count_en))
    else $error("near-full pulse without a count");

  a_upper_zero: assert property (
    count_reg[IDX_IN_RANGE][31:16] == 16'h0000 &&
    count_reg[IDX_PAUSE][31:16] == 16'h0000 &&
    count_reg[IDX_CTRL_TX][31:16] == 16'h0000)
    else $error("16-bit counter upper half not zero");

  a_late_step: assert property (
    tx_event_in.collision && tx_event_in.past_one_slot &&
    counters_global_on_in && !per_counter_mask_in[IDX_LATE] &&
    !write_hit[IDX_LATE]
    |=> count_reg[IDX_LATE] == $past(count_reg[IDX_LATE]) + 32'h00000001)
    else $error("late collision not counted");

  a_pause_step: assert property (
    rx_info_in.done && rx_info_in.is_control &&
    rx_info_in.control_opcode == PAUSE_OPCODE &&
    !rx_info_in.too_long && !rx_info_in.fcs_error &&
    !rx_info_in.align_error && !rx_info_in.overrun &&
    counters_global_on_in && !per_counter_mask_in[IDX_PAUSE] &&
    !write_hit[IDX_PAUSE]
    |=> count_reg[IDX_PAUSE] ==
        (($past(count_reg[IDX_PAUSE]) + 32'h00000001) & MASK_16))
    else $error("good pause frame not counted");

  a_ctrl_step: assert property (
    tx_event_in.ctrl_frame_sent && !tx_event_in.ctrl_from_host &&
    counters_global_on_in && !per_counter_mask_in[IDX_CTRL_TX] &&
    !write_hit[IDX_CTRL_TX]
    |=> count_reg[IDX_CTRL_TX] ==
        (($past(count_reg[IDX_CTRL_TX]) + 32'h00000001) & MASK_16))
    else $error("device control frame not counted");

  a_mcst_step: assert property (
    rx_info_in.done && rx_info_in.dest_addr[GROUP_BIT] &&
    rx_info_in.dest_addr != BROADCAST &&
    rx_info_in.length_type == rx_info_in.data_octets &&
    !rx_info_in.too_long && !rx_info_in.fcs_error &&
    !rx_info_in.align_error && !rx_info_in.overrun &&
    counters_global_on_in && !per_counter_mask_in[IDX_MCST] &&
    !write_hit[IDX_MCST]
    |=> count_reg[IDX_MCST] == $past(count_reg[IDX_MCST]) + 32'h00000001)
    else $error("good multicast frame not counted");

  a_write_wins: assert property (
    write_hit[IDX_LATE] && count_en[IDX_LATE]
    |=> count_reg[IDX_LATE] == $past(reg_req_in.wdata))
    else $error("event beat a write to late collision counter");

  a_read_valid: assert property (
    reg_rvalid_out == $past(reg_req_in.rd))
    else $error("read valid not one cycle after read strobe");

  a_read_unmapped: assert property (
    reg_req_in.rd && !(|read_hit) |=> reg_rdata_out == READ_UNMAPPED)
    else $error("unmapped read returned nonzero data");

  c_near_full: cover property (counter_near_full_event_out);
  c_mcst_wrap: cover property (
    count_en[IDX_MCST] && count_reg[IDX_MCST] == 32'hFFFFFFFF);
  c_write_vs_event: cover property (write_hit[IDX_LATE] && count_en[IDX_LATE]);
  c_read_back: cover property (
    reg_req_in.wr ##2 reg_req_in.rd ##1 reg_rvalid_out);

endmodule : stat_counters

//--- rtl/stat_counters_pkg.sv
// constants and carrier types for the mac error and frame statistic counters
// assumes the frame parser and the collision logic share clk_in with the bank
package stat_counters_pkg;

  localparam int NUM_COUNTERS = 5;

  // counter slots, also the bit order of the mask input
  localparam int IDX_IN_RANGE = 0;
  localparam int IDX_LATE = 1;
  localparam int IDX_PAUSE = 2;
  localparam int IDX_CTRL_TX = 3;
  localparam int IDX_MCST = 4;

  localparam logic [7:0] ADDR_IN_RANGE = 8'hF0;
  localparam logic [7:0] ADDR_LATE = 8'hF4;
  localparam logic [7:0] ADDR_PAUSE = 8'hF8;
  localparam logic [7:0] ADDR_CTRL_TX = 8'hFA;
  localparam logic [7:0] ADDR_MCST = 8'hB8;

  localparam logic [31:0] MASK_16 = 32'h0000FFFF;
  localparam logic [31:0] MASK_32 = 32'hFFFFFFFF;
  localparam logic [31:0] NEAR_16 = 32'h0000C000;
  localparam logic [31:0] NEAR_32 = 32'hC0000000;
  localparam logic [31:0] COUNT_RESET = 32'h00000000;
  localparam logic [31:0] READ_UNMAPPED = 32'h00000000;

  localparam logic [15:0] MIN_UNPADDED = 16'h002E;
  localparam logic [15:0] MAX_CLIENT = 16'h05DC;
  localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
  localparam logic [47:0] BROADCAST = 48'hFFFFFFFFFFFF;
  // first octet on the wire sits in [47:40], its lsb is the group bit
  localparam int GROUP_BIT = 40;

  typedef struct packed {
    logic done;
    logic [15:0] length_type;
    logic [15:0] data_octets;
    logic [47:0] dest_addr;
    logic too_long;
    logic fcs_error;
    logic align_error;
    logic overrun;
    logic is_control;
    logic [15:0] control_opcode;
  } rx_frame_info_type;

  typedef struct packed {
    logic collision;
    logic past_one_slot;
    logic ctrl_frame_sent;
    logic ctrl_from_host;
  } tx_event_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_type;

endpackage : stat_counters_pkg

//--- testbench/tb.sv
// self-checking bench for the statistic counter bank
// assumes stat_counters alone on one 100 MHz clock; no partner model
`timescale 1ns/1ps
`define CHK(got, want) begin \
  compares++; \
  if ((got) !== (want)) begin \
    err_count++; \
    $display("Error at %0t: got %h expected %h", $time, got, want); \
  end \
end
module tb
  import stat_counters_pkg::*;
;
  typedef struct packed {
    rx_frame_info_type rx;
    tx_event_type tx;
    logic on;
    logic [4:0] mask;
    logic [4:0] bump;
  } row_type;
  localparam logic [47:0] UNI = 48'h020000000001;
  localparam logic [47:0] MC = 48'h01005E000001;
  localparam int N = 20;
  logic clk, resetn, rvalid, near_full, glob_on;
  logic [4:0] mask;
  logic [31:0] rdata;
  reg_req_type req;
  rx_frame_info_type rx;
  tx_event_type tx;
  int err_count = 0;
  int compares = 0;
  row_type rows [N];
  logic [31:0] exp_cnt [5];
  logic [7:0] addr_tab [5] = '{ADDR_IN_RANGE, ADDR_LATE, ADDR_PAUSE,
    ADDR_CTRL_TX, ADDR_MCST};
  logic [31:0] wm [5] = '{MASK_16, MASK_32, MASK_16, MASK_16, MASK_32};
  logic [31:0] nr [5] = '{NEAR_16, NEAR_32, NEAR_16, NEAR_16, NEAR_32};
  // one row per counter that steps exactly that counter
  int sel [5] = '{0, 13, 11, 15, 1};

  stat_counters i_dut (
    .clk_in(clk),
    .resetn_in(resetn),
    .reg_req_in(req),
    .reg_rdata_out(rdata),
    .reg_rvalid_out(rvalid),
    .counters_global_on_in(glob_on),
    .per_counter_mask_in(mask),
    .rx_info_in(rx),
    .tx_event_in(tx),
    .counter_near_full_event_out(near_full)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic test_done();
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  // rx rows carry done, tx rows do not; c=1 pause, c=2 other opcode
  function automatic row_type mk(logic [15:0] len, logic [15:0] oct,
      logic [47:0] d, logic [3:0] e, logic [1:0] c, logic [3:0] t,
      logic o, logic [4:0] m, logic [4:0] b);
    row_type r;
    r = '0;
    r.rx.done = (t == 4'h0);
    r.rx.length_type = len;
    r.rx.data_octets = oct;
    r.rx.dest_addr = d;
    {r.rx.too_long, r.rx.fcs_error, r.rx.align_error, r.rx.overrun} = e;
    r.rx.is_control = |c;
    r.rx.control_opcode = {14'h0000, c};
    r.tx = t;
    r.on = o;
    r.mask = m;
    r.bump = b;
    return r;
  endfunction : mk

  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    @(negedge clk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk);
    req.rd = 1'b0;
    `CHK(rvalid, 1'b1)
    `CHK(rdata, want)
  endtask : rd

  task automatic wr_reg(input int i, input logic [31:0] v);
    @(negedge clk);
    req.wr = 1'b1;
    req.addr = addr_tab[i];
    req.wdata = v;
    @(negedge clk);
    req.wr = 1'b0;
    exp_cnt[i] = v & wm[i];
  endtask : wr_reg

  task automatic check_all();
    for (int i = 0; i < 5; i++) begin
      rd(addr_tab[i], exp_cnt[i]);
    end
  endtask : check_all

  task automatic apply(input row_type r);
    logic hit;
    hit = 1'b0;
    @(negedge clk);
    rx = r.rx;
    tx = r.tx;
    glob_on = r.on;
    mask = r.mask;
    @(negedge clk);
    rx = '0;
    tx = '0;
    for (int i = 0; i < 5; i++) begin
      if (r.bump[i]) begin
        exp_cnt[i] = (exp_cnt[i] + 32'h00000001) & wm[i];
        if (exp_cnt[i] == nr[i]) hit = 1'b1;
      end
    end
    `CHK(near_full, hit)
    @(negedge clk);
    `CHK(near_full, 1'b0)
    check_all();
  endtask : apply

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    test_done();
  end

  initial begin
    resetn = 1'b0;
    req = '0;
    rx = '0;
    tx = '0;
    glob_on = 1'b1;
    mask = 5'h00;
    for (int i = 0; i < 5; i++) exp_cnt[i] = 32'h00000000;
    rows[0] = mk(16'h0040, 16'h0041, UNI, 0, 0, 0, 1, 0, 5'h01);
    rows[1] = mk(16'h002E, 16'h002E, MC, 0, 0, 0, 1, 0, 5'h10);
    rows[2] = mk(16'h05DC, 16'h05DB, MC, 0, 0, 0, 1, 0, 5'h01);
    rows[3] = mk(16'h0010, 16'h002F, UNI, 0, 0, 0, 1, 0, 5'h01);
    rows[4] = mk(16'h0010, 16'h002E, UNI, 0, 0, 0, 1, 0, 5'h00);
    rows[5] = mk(16'h0600, 16'h0040, MC, 0, 0, 0, 1, 0, 5'h10);
    rows[6] = mk(16'h002E, 16'h002E, BROADCAST, 0, 0, 0, 1, 0, 5'h00);
    for (int k = 0; k < 4; k++) begin
      rows[7+k] = mk(16'h0040, 16'h0040, MC, 4'h8 >> k, 0, 0, 1, 0, 0);
    end
    rows[11] = mk(16'h8808, 16'h002E, UNI, 0, 1, 0, 1, 0, 5'h04);
    rows[12] = mk(16'h8808, 16'h002E, UNI, 0, 2, 0, 1, 0, 5'h00);
    rows[13] = mk(0, 0, UNI, 0, 0, 4'hC, 1, 0, 5'h02);
    rows[14] = mk(0, 0, UNI, 0, 0, 4'h8, 1, 0, 5'h00);
    rows[15] = mk(0, 0, UNI, 0, 0, 4'h2, 1, 0, 5'h08);
    rows[16] = mk(0, 0, UNI, 0, 0, 4'h3, 1, 0, 5'h00);
    rows[17] = mk(16'h002E, 16'h002E, MC, 0, 0, 0, 1, 5'h10, 0);
    rows[18] = mk(16'h002E, 16'h002E, MC, 0, 0, 0, 0, 0, 0);
    rows[19] = mk(16'h0040, 16'h0041, UNI, 0, 0, 0, 1, 5'h01, 0);
    repeat (5) @(negedge clk);
    `CHK(near_full, 1'b0)
    `CHK(rvalid, 1'b0)
    `CHK(rdata, 32'h00000000)
    resetn = 1'b1;
    check_all();
    for (int k = 0; k < N; k++) begin
      apply(rows[k]);
    end
    // wrap from all ones, then step onto each near-full threshold
    for (int i = 0; i < 5; i++) begin
      wr_reg(i, wm[i]);
      apply(rows[sel[i]]);
      wr_reg(i, nr[i] - 32'h00000001);
      apply(rows[sel[i]]);
      wr_reg(i, nr[i]);
      `CHK(near_full, 1'b0)
    end
    // upper half of a 16-bit counter is dropped on write
    wr_reg(0, 32'h12345678);
    rd(ADDR_IN_RANGE, 32'h00005678);
    @(negedge clk);
    req.wr = 1'b1;
    req.addr = 8'h00;
    req.wdata = 32'hA5A5A5A5;
    @(negedge clk);
    req.wr = 1'b0;
    rd(8'h00, READ_UNMAPPED);
    // write and counted event in one cycle: the write wins
    @(negedge clk);
    tx = 4'hC;
    req.wr = 1'b1;
    req.addr = ADDR_LATE;
    req.wdata = 32'h00000005;
    @(negedge clk);
    tx = '0;
    req.wr = 1'b0;
    exp_cnt[1] = 32'h00000005;
    rd(ADDR_LATE, exp_cnt[1]);
    check_all();
    // reset in mid-run clears every counter
    @(negedge clk);
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    `CHK(near_full, 1'b0)
    `CHK(rvalid, 1'b0)
    `CHK(rdata, 32'h00000000)
    resetn = 1'b1;
    for (int i = 0; i < 5; i++) exp_cnt[i] = 32'h00000000;
    check_all();
    test_done();
  end
endmodule : tb
